// [src/pisr_pkg.sv]
// Shared constants for the interrupt source status block
package pisr_pkg;

    // ----------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------
    localparam logic [7:0] INTERRUPT_SOURCE_REGISTER_OFS = 8'h00;
    localparam logic [7:0] INTERRUPT_ENABLE_REGISTER_OFS = 8'h04;

    // ----------------------------------------
    // Field positions, shared by both registers
    // ----------------------------------------
    localparam int POWER_STATE_CHANGE_BIT = 0;
    localparam int TARGET_ABORT_SEEN_BIT = 1;
    localparam int MASTER_ABORT_SEEN_BIT = 2;
    localparam int HOST_SOFTWARE_REQUEST_BIT = 3;
    localparam int WAKE_PIN_RISE_BIT = 4;
    localparam int WAKE_PIN_FALL_BIT = 5;
    localparam int MASTER_TRANSFER_DONE_BIT = 6;
    localparam int CONFIG_LOAD_COMPLETE_BIT = 7;
    localparam int CONFIG_CHECKSUM_ERROR_BIT = 8;
    localparam int EEPROM_READY_FLAG_BIT = 9;
    localparam int RESERVED_FLAG_BIT = 10;
    localparam int BUS_RESET_CHANGE_FLAG_BIT = 11;
    localparam int FLAG_W = 12;

    // ----------------------------------------
    // Writable bits and reset values
    // ----------------------------------------
    localparam logic [FLAG_W-1:0] FLAG_MASK = 12'hBFF;
    localparam logic [FLAG_W-1:0] STATUS_RESET = 12'h000;
    localparam logic [FLAG_W-1:0] ENABLE_RESET = 12'h008;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// [src/pisr_flag_bank.sv]
// Sticky event flags with write-one-to-clear and a bulk wipe
`timescale 1ns/1ps

module pisr_flag_bank #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wipe,
    input wire logic [W-1:0] set_vec,
    input wire logic [W-1:0] clr_vec,
    output logic [W-1:0] flags
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (W < 1) begin : g_bad_width
        $error("pisr_flag_bank: W must be at least 1");
    end

    // Set wins over clear so an event landing on a clear is never lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else if (wipe) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr_vec) | set_vec;
        end
    end

endmodule

// [src/pisr_top.sv]
// Interrupt source status and enable registers behind an Avalon-MM slave
`timescale 1ns/1ps

// What this block does
// - Flag bus reset input change as bit 11
// - Flag EEPROM ready as bit 9, zero otherwise
// - Flag checksum failure of autoinit as bit 8
// - Replay checksum error after warm reset if loaded
// - Flag config load complete bit 7, replay too
// - Flag completed master transaction as bit 6
// - Flag wake pin falling edge as bit 5
// - Flag wake pin rising edge as bit 4
// - Host doorbell request sets bit 3
// - Flag master abort as bit 2
// - Flag target abort as bit 1
// - Flag power state change, not when clocks stopped
// - Device and warm reset clear all flags
// - Bit 10 reserved, reads zero, writes ignored
// - Interrupt only for enabled sources
// - Only host request enabled after reset
// - Write one clears flag, zero/read no effect
module pisr_top
    import pisr_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic warm_rst,
    input wire logic bus_reset_in,
    input wire logic eeprom_ready,
    input wire logic config_load_done,
    input wire logic config_checksum_bad,
    input wire logic master_transfer_done,
    input wire logic master_abort_seen,
    input wire logic target_abort_seen,
    input wire logic power_wake_pin,
    input wire logic host_to_cpu_doorbell,
    input wire logic power_state_change,
    input wire logic dsp_clocks_running,
    output logic cpu_irq
);

    // ----------------------------------------
    // Types, checks and helpers
    // ----------------------------------------
    typedef enum logic {
        PISR_IDLE = 1'b0,
        PISR_ACK = 1'b1
    } pisr_state_t;

    if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
        $error("pisr_top: ADDR_W must be 3..8 to hold both offsets");
    end

    // Expands byte enables to a bit mask over the flag field
    function automatic logic [FLAG_W-1:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return m[FLAG_W-1:0];
    endfunction

    // Matches a bus address against a register offset
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ofs[ADDR_W-1:0];
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;

    // Two stages so the release is clean against clk
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    pisr_state_t state;
    pisr_state_t next_state;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enable;
    logic access_done;
    logic status_wr;
    logic enable_wr;
    logic [FLAG_W-1:0] wr_bits;

    // A request is completed in the cycle waitrequest is low
    assign access_done = (state == PISR_ACK);
    assign wr_bits = writedata[FLAG_W-1:0] & lane_mask(byteenable) & FLAG_MASK;
    assign status_wr = access_done && write && hit(address, INTERRUPT_SOURCE_REGISTER_OFS);
    assign enable_wr = access_done && write && hit(address, INTERRUPT_ENABLE_REGISTER_OFS);

    // Handshake sequencing
    always_comb begin
        case (state)
            PISR_IDLE: next_state = (read || write) ? PISR_ACK : PISR_IDLE;
            PISR_ACK: next_state = PISR_IDLE;
            default: next_state = PISR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PISR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Waitrequest is a flop; low for exactly the completing cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= (next_state != PISR_ACK);
        end
    end

    // Read data captured on entry to the ack cycle, held until next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (state == PISR_IDLE && read) begin
            if (hit(address, INTERRUPT_SOURCE_REGISTER_OFS)) begin
                readdata <= {{(32-FLAG_W){1'b0}}, flags & FLAG_MASK};
            end else if (hit(address, INTERRUPT_ENABLE_REGISTER_OFS)) begin
                readdata <= {{(32-FLAG_W){1'b0}}, enable & FLAG_MASK};
            end else begin
                readdata <= UNMAPPED_READ;
            end
        end
    end

    // ----------------------------------------
    // Enable register
    // ----------------------------------------
    // host request alone enabled after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= ENABLE_RESET;
        end else if (warm_rst) begin
            enable <= ENABLE_RESET; // Warm reset also restores defaults
        end else if (enable_wr) begin
            enable <= (enable & ~(lane_mask(byteenable) & FLAG_MASK)) | wr_bits;
        end
    end

    // ----------------------------------------
    // Edge detection on level inputs
    // ----------------------------------------
    logic primed;
    logic bus_reset_q;
    logic wake_q;
    logic eeprom_q;
    logic warm_q;

    // Primed keeps a pin high out of reset from looking like an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            primed <= 1'b0;
            bus_reset_q <= 1'b0;
            wake_q <= 1'b0;
            eeprom_q <= 1'b0;
            warm_q <= 1'b0;
        end else begin
            primed <= 1'b1;
            bus_reset_q <= bus_reset_in;
            wake_q <= power_wake_pin;
            eeprom_q <= eeprom_ready;
            warm_q <= warm_rst;
        end
    end

    // ----------------------------------------
    // Autoinit history, survives warm reset
    // ----------------------------------------
    logic cfg_loaded;
    logic cfg_bad;
    logic warm_release;

    assign warm_release = warm_q && !warm_rst;

    // Only device reset forgets a finished load
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_loaded <= 1'b0;
            cfg_bad <= 1'b0;
        end else if (config_load_done) begin
            cfg_loaded <= 1'b1;
            cfg_bad <= config_checksum_bad;
        end
    end

    // ----------------------------------------
    // Event set and clear vectors
    // ----------------------------------------
    logic [FLAG_W-1:0] set_vec;
    logic [FLAG_W-1:0] clr_vec;

    always_comb begin
        set_vec = '0;
        set_vec[BUS_RESET_CHANGE_FLAG_BIT] = primed && (bus_reset_in != bus_reset_q);
        set_vec[EEPROM_READY_FLAG_BIT] = primed && eeprom_ready && !eeprom_q;
        set_vec[CONFIG_CHECKSUM_ERROR_BIT] = (config_load_done && config_checksum_bad)
            || (warm_release && cfg_loaded && cfg_bad); // replay
        // load complete, or replay after warm
        set_vec[CONFIG_LOAD_COMPLETE_BIT] = config_load_done || (warm_release && cfg_loaded);
        set_vec[MASTER_TRANSFER_DONE_BIT] = master_transfer_done;
        set_vec[WAKE_PIN_FALL_BIT] = primed && !power_wake_pin && wake_q;
        set_vec[WAKE_PIN_RISE_BIT] = primed && power_wake_pin && !wake_q;
        set_vec[HOST_SOFTWARE_REQUEST_BIT] = host_to_cpu_doorbell;
        set_vec[MASTER_ABORT_SEEN_BIT] = master_abort_seen;
        set_vec[TARGET_ABORT_SEEN_BIT] = target_abort_seen;
        set_vec[POWER_STATE_CHANGE_BIT] = power_state_change && dsp_clocks_running;
    end

    always_comb begin
        clr_vec = status_wr ? wr_bits : '0;
        // not ready forces the flag low
        clr_vec[EEPROM_READY_FLAG_BIT] = clr_vec[EEPROM_READY_FLAG_BIT] || !eeprom_ready;
    end

    // warm reset wipes, device reset via rst_n
    pisr_flag_bank #(
        .W(FLAG_W)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .wipe(warm_rst),
        .set_vec(set_vec & FLAG_MASK),
        .clr_vec(clr_vec),
        .flags(flags)
    );

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    // level while any enabled flag is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_irq <= 1'b0;
        end else begin
            cpu_irq <= |(flags & enable); // gating by enables
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    bus_reset_flag_a: assert property (
        (primed && bus_reset_in != bus_reset_q && !warm_rst)
            |=> flags[BUS_RESET_CHANGE_FLAG_BIT])
        else $error("bus reset change not flagged");

    eeprom_low_a: assert property (
        !eeprom_ready |=> !flags[EEPROM_READY_FLAG_BIT])
        else $error("eeprom flag set while not ready");

    cfg_error_a: assert property (
        (config_load_done && config_checksum_bad && !warm_rst)
            |=> flags[CONFIG_CHECKSUM_ERROR_BIT] && flags[CONFIG_LOAD_COMPLETE_BIT])
        else $error("checksum failure not flagged");

    error_replay_a: assert property (
        (warm_release && cfg_loaded && cfg_bad)
            |=> flags[CONFIG_CHECKSUM_ERROR_BIT])
        else $error("checksum error not replayed after warm reset");

    done_replay_a: assert property (
        (warm_release && cfg_loaded) |=> flags[CONFIG_LOAD_COMPLETE_BIT])
        else $error("load complete not replayed after warm reset");

    master_done_a: assert property (
        (master_transfer_done && !warm_rst) |=> flags[MASTER_TRANSFER_DONE_BIT])
        else $error("master completion not flagged");

    wake_fall_a: assert property (
        (primed && $fell(power_wake_pin) && !warm_rst) |=> flags[WAKE_PIN_FALL_BIT])
        else $error("wake pin fall not flagged");

    wake_rise_a: assert property (
        (primed && $rose(power_wake_pin) && !warm_rst) |=> flags[WAKE_PIN_RISE_BIT])
        else $error("wake pin rise not flagged");

    doorbell_a: assert property (
        (host_to_cpu_doorbell && !warm_rst) |=> flags[HOST_SOFTWARE_REQUEST_BIT])
        else $error("host doorbell not flagged");

    aborts_a: assert property (
        (master_abort_seen && !warm_rst) |=> flags[MASTER_ABORT_SEEN_BIT])
        else $error("master abort not flagged");

    target_abort_a: assert property (
        (target_abort_seen && !warm_rst) |=> flags[TARGET_ABORT_SEEN_BIT])
        else $error("target abort not flagged");

    pm_gate_a: assert property (
        (!flags[POWER_STATE_CHANGE_BIT] && !dsp_clocks_running)
            |=> !flags[POWER_STATE_CHANGE_BIT])
        else $error("power flag set with clocks stopped");

    warm_clear_a: assert property (
        warm_rst |=> flags == STATUS_RESET && enable == ENABLE_RESET)
        else $error("warm reset did not clear flags");

    reserved_bit_a: assert property (
        !flags[RESERVED_FLAG_BIT] && !readdata[RESERVED_FLAG_BIT])
        else $error("reserved bit seen set");

    irq_gate_a: assert property (
        ((flags & enable) == '0) [*2] |-> !cpu_irq)
        else $error("interrupt without enabled flag");

    irq_level_a: assert property (
        ((flags & enable) != '0) |=> cpu_irq)
        else $error("enabled flag did not raise interrupt");

    enable_reset_a: assert property (
        $rose(primed) |-> enable == ENABLE_RESET)
        else $error("enable register reset value wrong");

    w1c_a: assert property (
        (status_wr && wr_bits[HOST_SOFTWARE_REQUEST_BIT]
            && !set_vec[HOST_SOFTWARE_REQUEST_BIT])
            |=> !flags[HOST_SOFTWARE_REQUEST_BIT])
        else $error("write one did not clear flag");

    wait_pulse_a: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    status_read_c: cover property (
        read && hit(address, INTERRUPT_SOURCE_REGISTER_OFS) ##1 !waitrequest);
    clear_write_c: cover property (status_wr && wr_bits != '0);
    irq_rise_c: cover property ($rose(cpu_irq));
    warm_replay_c: cover property (warm_release && cfg_loaded);

endmodule

// [testbench/pisr_host_model.sv]
// Far-side model: host, bus and event sources feeding the status block
`timescale 1ns/1ps

module pisr_host_model (
    input wire logic clk,
    input wire logic [11:0] kick,
    output logic bus_reset_in,
    output logic eeprom_ready,
    output logic config_load_done,
    output logic config_checksum_bad,
    output logic master_transfer_done,
    output logic master_abort_seen,
    output logic target_abort_seen,
    output logic power_wake_pin,
    output logic host_to_cpu_doorbell,
    output logic power_state_change
);
    // ----------------------------------------
    // Event generation
    // ----------------------------------------
    // Levels toggle on request so that each kick is exactly one edge
    // One process owns every output so nothing has two drivers
    initial begin
        bus_reset_in = 1'b0;
        eeprom_ready = 1'b0;
        power_wake_pin = 1'b0;
        config_load_done = 1'b0;
        config_checksum_bad = 1'b0;
        master_transfer_done = 1'b0;
        host_to_cpu_doorbell = 1'b0;
        master_abort_seen = 1'b0;
        target_abort_seen = 1'b0;
        power_state_change = 1'b0;
        forever begin
            @(posedge clk);
            bus_reset_in <= bus_reset_in ^ kick[11];
            eeprom_ready <= eeprom_ready ^ kick[9];
            config_load_done <= kick[7] | kick[8];
            config_checksum_bad <= kick[8];
            master_transfer_done <= kick[6];
            power_wake_pin <= power_wake_pin ^ (kick[4] | kick[5]);
            host_to_cpu_doorbell <= kick[3];
            master_abort_seen <= kick[2];
            target_abort_seen <= kick[1];
            power_state_change <= kick[0];
        end
    end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the interrupt source status block
`timescale 1ns/1ps

module tb_top;
    import pisr_pkg::*;

    logic clk, nrst, read, write, warm_rst, dsp_clocks_running;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, rnd;
    logic waitrequest, cpu_irq;
    logic [11:0] kick;
    logic bus_reset_in, eeprom_ready, config_load_done, config_checksum_bad;
    logic master_transfer_done, master_abort_seen, target_abort_seen;
    logic power_wake_pin, host_to_cpu_doorbell, power_state_change;
    logic [31:0] exp_q[$];
    int order[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 11};
    int failures = 0;
    int checks_done = 0;
    int seed = 89423;

    // ----------------------------------------
    // Clock and instances
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    pisr_top #(.ADDR_W(4)) dut (
        .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .warm_rst(warm_rst), .bus_reset_in(bus_reset_in),
        .eeprom_ready(eeprom_ready), .config_load_done(config_load_done),
        .config_checksum_bad(config_checksum_bad),
        .master_transfer_done(master_transfer_done), .master_abort_seen(master_abort_seen),
        .target_abort_seen(target_abort_seen), .power_wake_pin(power_wake_pin),
        .host_to_cpu_doorbell(host_to_cpu_doorbell), .power_state_change(power_state_change),
        .dsp_clocks_running(dsp_clocks_running), .cpu_irq(cpu_irq)
    );

    pisr_host_model host (
        .clk(clk), .kick(kick), .bus_reset_in(bus_reset_in), .eeprom_ready(eeprom_ready),
        .config_load_done(config_load_done), .config_checksum_bad(config_checksum_bad),
        .master_transfer_done(master_transfer_done), .master_abort_seen(master_abort_seen),
        .target_abort_seen(target_abort_seen), .power_wake_pin(power_wake_pin),
        .host_to_cpu_doorbell(host_to_cpu_doorbell), .power_state_change(power_state_change)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic bad(input string msg);
        failures++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic check_rd(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) bad($sformatf("readdata %h want %h", got, want));
    endtask

    task automatic check_irq(input logic want);
        checks_done++;
        if (cpu_irq !== want) bad($sformatf("cpu_irq %b want %b", cpu_irq, want));
    endtask

    // Hold the request until waitrequest is sampled low, then one idle edge
    // Only the watchdog ends a wait that never gets an answer
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= ~w;
        write <= w;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // Three edges let the model pulse and the flag land
    task automatic fire(input logic [11:0] k);
        kick <= k;
        @(posedge clk);
        kick <= 12'h000;
        repeat (3) @(posedge clk);
    endtask

    task automatic conclude();
        if (exp_q.size() != 0) bad("reads left unchecked");
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Monitor and watchdog
    // ----------------------------------------
    // Read data is valid from the completion edge and held after it, so compare there
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (exp_q.size() == 0) bad("read with no expectation");
            else check_rd(readdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        bad("watchdog expired");
        conclude();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        warm_rst = 1'b0;
        dsp_clocks_running = 1'b1;
        kick = 12'h000;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h0, 32'h0000_0000);
        rd(4'h4, 32'h0000_0008);
        rd(4'h8, 32'h0000_0000);
        // Each source but the checksum error sets its own bit only; only the doorbell is enabled
        foreach (order[i]) begin
            fire(12'h001 << order[i]);
            rd(4'h0, 32'h0000_0001 << order[i]);
            check_irq(order[i] == 3);
            wr(4'h0, 32'h0000_0000);
            rd(4'h0, 32'h0000_0001 << order[i]);
            wr(4'h0, 32'h0000_0001 << order[i]);
            rd(4'h0, 32'h0000_0000);
        end
        // Ready flag follows the EEPROM level down
        fire(12'h200);
        fire(12'h200);
        rd(4'h0, 32'h0000_0200);
        fire(12'h200);
        rd(4'h0, 32'h0000_0000);
        // Power transitions ignored with clocks stopped
        dsp_clocks_running <= 1'b0;
        fire(12'h001);
        rd(4'h0, 32'h0000_0000);
        dsp_clocks_running <= 1'b1;
        // Bad checksum load, lane-masked enable write, then warm reset replay
        fire(12'h100);
        rd(4'h0, 32'h0000_0180);
        rnd = $random(seed);
        byteenable <= 4'h1;
        wr(4'h4, rnd);
        byteenable <= 4'hF;
        rd(4'h4, rnd & 32'h0000_00FF);
        rnd = $random(seed);
        wr(4'h4, rnd);
        rd(4'h4, rnd & {20'h0_0000, FLAG_MASK});
        fire(12'h040);
        warm_rst <= 1'b1;
        @(posedge clk);
        warm_rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(4'h0, 32'h0000_0180);
        rd(4'h4, 32'h0000_0008);
        // Masking drops the interrupt level
        wr(4'h0, 32'hFFFF_FFFF);
        rd(4'h0, 32'h0000_0000);
        wr(4'h4, 32'h0000_0FFF);
        rd(4'h4, 32'h0000_0BFF);
        fire(12'h004);
        check_irq(1'b1);
        wr(4'h4, 32'h0000_0000);
        repeat (2) @(posedge clk);
        check_irq(1'b0);
        // Device reset in mid-run wipes a pending flag
        fire(12'h040);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h0, 32'h0000_0000);
        rd(4'h4, 32'h0000_0008);
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule
